/* File: bench/frs_ref_model.sv */
`timescale 1ns/1ps
// Sensor front end: samples the requested values once per clock, as a converter would.
module frs_ref_model
  import frs_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Values to present
  input wire logic signed [frs_pkg::FREQ_W-1:0] i_pid,
  input wire logic signed [frs_pkg::FREQ_W-1:0] i_seq,
  input wire logic [frs_pkg::PCT_W-1:0] i_pulse,
  input wire logic signed [frs_pkg::PCT_W-1:0] i_ain,
  // Channels towards the block
  output frs_pkg::frs_chan_t o_chan
);
  always_ff @(posedge i_sys_clk) begin
    o_chan.ain_one <= i_ain;
    o_chan.ain_two <= 16'h0000;
    o_chan.ain_bip <= 16'h0000;
    o_chan.pot <= 16'h0000;
    o_chan.pulse_rate <= i_pulse;
    o_chan.pid_freq <= i_pid;
    o_chan.seq_freq <= i_seq;
  end
endmodule // frs_ref_model

/* File: bench/frs_top_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); end end
module frs_top_bench;
  import frs_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  frs_bus_t bus = '0;
  logic [DATA_W-1:0] o_rdata;
  frs_chan_t chan;
  logic [3:0] terms = 4'h0;
  logic sw = 1'b0;
  logic signed [FREQ_W-1:0] tgt;
  logic signed [FREQ_W-1:0] pid = 18'h00000;
  logic signed [FREQ_W-1:0] seq = 18'h00000;
  logic [PCT_W-1:0] pulse = 16'h0000;
  logic signed [PCT_W-1:0] ain = 16'h0000;
  logic up = 1'b0;
  logic dn = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic signed [FREQ_W-1:0] exp_t [7] = '{18'sd1000, -18'sd1200, 18'sd1000, -18'sd195,
    18'sd2205, -18'sd1195, 18'sd1005};

  always #10 i_sys_clk = ~i_sys_clk;

  frs_ref_model i_frs_ref_model (.i_sys_clk(i_sys_clk), .i_pid(pid), .i_seq(seq),
    .i_pulse(pulse), .i_ain(ain), .o_chan(chan));
  frs_top i_frs_top (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(o_rdata),
    .i_chan(chan), .i_step_terms(terms), .i_switch_term(sw), .i_up(up), .i_down(dn),
    .o_target_freq(tgt));

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // The target is recomputed two edges after a setting lands; four leaves margin.
  task automatic settle();
    repeat (4) @(posedge i_sys_clk);
  endtask

  task automatic t_reset_vals();
    logic [15:0] d;
    rd(OFS_AUX_SRC, d);
    `CHK(d, 16'h0000)
    rd(OFS_AUX_RANGE, d);
    `CHK(d, 16'h0000)
    rd(OFS_COMB_MODE, d);
    `CHK(d, 16'h0000)
    rd(8'h40, d);
    `CHK(d, 16'h0000)
  endtask

  task automatic t_combine();
    logic [15:0] d;
    @(posedge i_sys_clk);
    pid <= 18'sd1000;
    seq <= -18'sd1200;
    wr(OFS_MAIN_SRC, 16'h0008);
    wr(OFS_AUX_SRC, 16'h0007);
    wr(OFS_COMB_OFS, 16'h0005);
    for (int m = 0; m < 7; m++) begin
      wr(OFS_COMB_MODE, 16'(m));
      settle();
      rd(OFS_SRC_A, d);
      rd(OFS_SRC_B, d);
      rd(OFS_TARGET, d);
      `CHK(tgt, exp_t[m])
      if (m == 2) begin
        @(posedge i_sys_clk);
        sw <= 1'b1;
        settle();
        rd(OFS_TARGET, d);
        `CHK(tgt, -18'sd1200)
        @(posedge i_sys_clk);
        sw <= 1'b0;
      end
    end
  endtask

  task automatic t_sources();
    wr(OFS_COMB_MODE, 16'h0000);
    wr(OFS_MAIN_SRC, 16'h0009);
    wr(OFS_COMM_FREQ, 16'h0929);
    settle();
    `CHK(tgt, 18'sd2345)
    wr(OFS_STEP_BASE + 8'h05, 16'h1388);
    wr(OFS_STEP_BASE + 8'h0F, 16'h2710);
    wr(OFS_MAIN_SRC, 16'h0006);
    @(posedge i_sys_clk);
    terms <= 4'h5;
    settle();
    `CHK(tgt, 18'sd2500)
    @(posedge i_sys_clk);
    terms <= 4'hF;
    settle();
    `CHK(tgt, 18'sd5000)
    wr(OFS_MAIN_SRC, 16'h0005);
    @(posedge i_sys_clk);
    pulse <= 16'h01F4;
    settle();
    `CHK(tgt, 18'sd2500)
    @(posedge i_sys_clk);
    pulse <= 16'h03E8;
    settle();
    `CHK(tgt, 18'sd5000)
  endtask

  task automatic t_aux_scale();
    wr(OFS_MAIN_SRC, 16'h0008);
    wr(OFS_AUX_SRC, 16'h0005);
    // The auxiliary range only applies when B takes part in arithmetic.
    wr(OFS_COMB_MODE, 16'h0003);
    @(posedge i_sys_clk);
    pulse <= 16'h01F4;
    settle();
    `CHK(tgt, 18'sd3505)
    wr(OFS_AUX_RANGE, 16'h0001);
    settle();
    `CHK(tgt, 18'sd1505)
    wr(OFS_AUX_RANGE, 16'h0000);
  endtask

  // The preset must not leak into the sum when the keypad is the auxiliary source.
  task automatic t_keypad_aux();
    wr(OFS_AUX_SRC, 16'h0000);
    wr(OFS_KEYPAD, 16'h02BC);
    wr(OFS_COMB_MODE, 16'h0003);
    settle();
    `CHK(tgt, 18'sd1005)
    wr(OFS_AUX_SRC, 16'h0009);
    wr(OFS_MAIN_SRC, 16'h0000);
    wr(OFS_COMB_MODE, 16'h0000);
    settle();
    `CHK(tgt, 18'sd700)
    @(posedge i_sys_clk);
    up <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    up <= 1'b0;
    settle();
    `CHK(tgt, 18'sd703)
    @(posedge i_sys_clk);
    dn <= 1'b1;
    @(posedge i_sys_clk);
    dn <= 1'b0;
    settle();
    `CHK(tgt, 18'sd702)
  endtask

  // First analog input through curve 0, then with its upper point lowered to half.
  task automatic t_analog();
    wr(OFS_MAIN_SRC, 16'h0002);
    @(posedge i_sys_clk);
    ain <= 16'h09C4;
    settle();
    `CHK(tgt, 18'sd1250)
    wr(OFS_CURVE_BASE + 8'h03, 16'h1388);
    settle();
    `CHK(tgt, 18'sd625)
  endtask

  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset_vals();
    t_combine();
    t_sources();
    t_aux_scale();
    t_keypad_aux();
    t_analog();
    report_and_stop();
  end
endmodule // frs_top_bench

/* File: bench/frs_top_sva.sv */
`timescale 1ns/1ps
module frs_top_sva
  import frs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire frs_pkg::frs_bus_t i_bus,
  input wire logic [frs_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_switch_term
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic rd_q;
  logic [ADDR_W-1:0] ra_q;
  logic [2:0] mode_q;
  logic [15:0] ofs_q;
  logic [15:0] a_q;
  logic [15:0] b_q;
  logic va_q;
  logic vb_q;
  logic tgt_rd;
  logic [15:0] mag_a;
  logic [15:0] mag_b;
  // Sources are learnt from reads of their registers; any write makes them stale.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= 1'b0;
      ra_q <= 8'h00;
      mode_q <= 3'h0;
      ofs_q <= 16'h0000;
      a_q <= 16'h0000;
      b_q <= 16'h0000;
      va_q <= 1'b0;
      vb_q <= 1'b0;
    end else begin
      rd_q <= i_bus.rd;
      ra_q <= i_bus.addr;
      if (i_bus.wr) begin
        va_q <= 1'b0;
        vb_q <= 1'b0;
        if (i_bus.addr == OFS_COMB_MODE) begin
          mode_q <= i_bus.wdata[2:0];
        end
        if (i_bus.addr == OFS_COMB_OFS) begin
          ofs_q <= i_bus.wdata;
        end
      end else if (rd_q && ra_q == OFS_SRC_A) begin
        a_q <= o_rdata;
        va_q <= 1'b1;
      end else if (rd_q && ra_q == OFS_SRC_B) begin
        b_q <= o_rdata;
        vb_q <= 1'b1;
      end
    end
  end
  assign tgt_rd = rd_q && ra_q == OFS_TARGET && va_q && vb_q;
  assign mag_a = a_q[15] ? 16'(-a_q) : a_q;
  assign mag_b = b_q[15] ? 16'(-b_q) : b_q;

  property p_rd_idle;
    !i_bus.rd |=> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero without read");
  property p_unmapped;
    i_bus.rd && i_bus.addr >= 8'h34 |=> o_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mode_a;
    tgt_rd && mode_q == CMB_A |-> o_rdata == a_q;
  endproperty
  a_mode_a: assert property (p_mode_a) else $error("mode A target wrong");
  property p_mode_b;
    tgt_rd && mode_q == CMB_B |-> o_rdata == b_q;
  endproperty
  a_mode_b: assert property (p_mode_b) else $error("mode B target wrong");
  property p_switch;
    $stable(i_switch_term)[*3] ##0 (tgt_rd && mode_q == CMB_SWITCH)
      |-> o_rdata == (i_switch_term ? b_q : a_q);
  endproperty
  a_switch: assert property (p_switch) else $error("switchover target wrong");
  property p_sum;
    tgt_rd && mode_q == CMB_SUM |-> o_rdata == 16'(a_q + b_q + ofs_q);
  endproperty
  a_sum: assert property (p_sum) else $error("sum target wrong");
  property p_diff;
    tgt_rd && mode_q == CMB_DIFF |-> o_rdata == 16'(a_q - b_q + ofs_q);
  endproperty
  a_diff: assert property (p_diff) else $error("difference target wrong");
  property p_max;
    tgt_rd && mode_q == CMB_MAX |-> o_rdata == 16'((mag_b > mag_a ? b_q : a_q) + ofs_q);
  endproperty
  a_max: assert property (p_max) else $error("maximum target wrong");
  property p_min;
    tgt_rd && mode_q == CMB_MIN |-> o_rdata == 16'((mag_b < mag_a ? b_q : a_q) + ofs_q);
  endproperty
  a_min: assert property (p_min) else $error("minimum target wrong");
endmodule // frs_top_sva

bind frs_top frs_top_sva i_frs_top_sva (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_bus(i_bus),
  .o_rdata(o_rdata),
  .i_switch_term(i_switch_term)
);

/* File: hdl/frs_step_mem.sv */
`timescale 1ns/1ps
// Sixteen-word table of multi-step references with a registered read port.
module frs_step_mem (
  // Clock
  input wire logic i_sys_clk,
  // Write port
  input wire logic i_we,
  input wire logic [3:0] i_waddr,
  input wire logic [15:0] i_wdata,
  // Read port
  input wire logic [3:0] i_raddr,
  output logic [15:0] o_rdata
);
  logic [15:0] mem_reg [16];

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_raddr];
  end
endmodule // frs_step_mem

/* File: hdl/frs_top.sv */
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Main select code picks main reference channel.
// - Five analog curves, assigned per input.
// - Pulse rate mapped by two-point line.
// - Pulse reference only from fast pulse input.
// - Four terminals pick one of sixteen steps.
// - Steps are percent of maximum frequency.
// - Sequencer supplies its running step frequency.
// - PID output used directly as frequency.
// - Communication written value drives main frequency.
// - Auxiliary select uses same channel codes.
// - Keypad auxiliary ignores preset during arithmetic.
// - Analog or pulse auxiliary scaled to range in arithmetic modes, else to maximum frequency.
// - Auxiliary range: maximum frequency or source A.
// - Combination mode chooses target frequency.
// - Arithmetic modes add combination offset.
// - Switchover terminal picks A or B.
// - Sum mode gives A plus B.
// - Difference mode gives A minus B.
// - Maximum mode picks larger magnitude.
// - Minimum mode picks smaller magnitude.
module frs_top
  import frs_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register port
  input wire frs_pkg::frs_bus_t i_bus,
  output logic [frs_pkg::DATA_W-1:0] o_rdata,
  // Reference channels and terminals
  input wire frs_pkg::frs_chan_t i_chan,
  input wire logic [3:0] i_step_terms,
  input wire logic i_switch_term,
  input wire logic i_up,
  input wire logic i_down,
  // Result
  output logic signed [frs_pkg::FREQ_W-1:0] o_target_freq
);
  import frs_pkg::*;

  localparam int PW = 40;

  logic [3:0] main_src_reg, main_src_next;
  logic [3:0] aux_src_reg, aux_src_next;
  logic [15:0] aux_range_reg, aux_range_next;
  logic [15:0] comb_mode_reg, comb_mode_next;
  logic signed [FREQ_W-1:0] comb_ofs_reg, comb_ofs_next;
  logic [FREQ_W-1:0] keypad_reg, keypad_next;
  logic [FREQ_W-1:0] fmax_reg, fmax_next;
  logic [3*CSEL_W-1:0] csel_reg, csel_next;
  logic [15:0] px0_reg, px0_next, py0_reg, py0_next;
  logic [15:0] px1_reg, px1_next, py1_reg, py1_next;
  logic signed [FREQ_W-1:0] comm_reg, comm_next;
  logic signed [FREQ_W-1:0] digital_reg, digital_next;
  logic signed [15:0] curve_reg [CURVES*4];
  logic signed [15:0] curve_next [CURVES*4];
  logic signed [FREQ_W-1:0] src_a_reg, src_a_next, src_b_reg, src_b_next;
  logic signed [FREQ_W-1:0] target_reg, target_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [15:0] step_pct;
  logic step_we;

  // Curve point table: per curve (x0,y0,x1,y1); curves 3,4 use two segments
  // (x0,y0)-(x1,y1)-(upper bank point) made of their first segment pair plus
  // a third point, so curves 3 and 4 hold two line segments of three points.
  function automatic logic signed [PCT_W-1:0] lerp(input logic signed [PCT_W-1:0] x,
      input logic signed [PCT_W-1:0] x0, input logic signed [PCT_W-1:0] y0,
      input logic signed [PCT_W-1:0] x1, input logic signed [PCT_W-1:0] y1);
    logic signed [PW-1:0] num;
    logic signed [PW-1:0] den;
    logic signed [PW-1:0] res;
    num = PW'(x - x0) * PW'(y1 - y0);
    den = PW'(x1 - x0);
    if (x <= x0) begin
      res = PW'(y0);
    end else if (x >= x1 || den == '0) begin
      res = PW'(y1);
    end else begin
      res = PW'(y0) + num / den;
    end
    return PCT_W'(res);
  endfunction

  // Percent of a full-scale frequency, percent in 0.01 % units.
  function automatic logic signed [FREQ_W-1:0] pct_of(input logic signed [PCT_W-1:0] pct,
      input logic signed [FREQ_W-1:0] full);
    logic signed [PW-1:0] prod;
    prod = PW'(pct) * PW'(full);
    return FREQ_W'(prod / PW'($signed({1'b0, PCT_FULL})));
  endfunction

  function automatic logic signed [FREQ_W-1:0] fabs(input logic signed [FREQ_W-1:0] v);
    return (v < 0) ? -v : v;
  endfunction

  // Curve number 0..4 applied to an analog percentage; 3 and 4 are three-point.
  function automatic logic signed [PCT_W-1:0] apply_curve(input logic [CSEL_W-1:0] c,
      input logic signed [PCT_W-1:0] x, input logic signed [15:0] pts [CURVES*4],
      input logic signed [15:0] ext [CURVES*4]);
    logic [4:0] b;
    b = 5'(c) << 2;
    if (c >= CSEL_W'(3) && x > pts[b+5'h2]) begin
      return lerp(x, pts[b+5'h2], pts[b+5'h3], ext[b], ext[b+5'h1]);
    end
    return lerp(x, pts[b], pts[b+5'h1], pts[b+5'h2], pts[b+5'h3]);
  endfunction

  logic signed [15:0] curve_ext_reg [CURVES*4];
  logic signed [15:0] curve_ext_next [CURVES*4];

  // Scaled value of one channel; full is the 100 % frequency for that use.
  function automatic logic signed [FREQ_W-1:0] chan_val(input logic [3:0] sel,
      input logic signed [FREQ_W-1:0] full, input logic is_aux);
    logic signed [PCT_W-1:0] p;
    logic signed [FREQ_W-1:0] v;
    v = '0;
    p = '0;
    case (sel)
      SRC_KEYPAD, SRC_KEYPAD_RET: v = is_aux ? '0 : digital_reg;
      SRC_AIN_ONE: p = apply_curve(csel_reg[0 +: CSEL_W], i_chan.ain_one, curve_reg,
          curve_ext_reg);
      SRC_AIN_TWO: p = apply_curve(csel_reg[CSEL_W +: CSEL_W], i_chan.ain_two, curve_reg,
          curve_ext_reg);
      SRC_AIN_BIP: p = apply_curve(csel_reg[2*CSEL_W +: CSEL_W], i_chan.ain_bip, curve_reg,
          curve_ext_reg);
      SRC_PULSE: p = lerp($signed(i_chan.pulse_rate), $signed(px0_reg), $signed(py0_reg),
          $signed(px1_reg), $signed(py1_reg));
      SRC_MULTI: v = pct_of($signed(step_pct), fmax_reg);
      SRC_SEQ: v = i_chan.seq_freq;
      SRC_PID: v = i_chan.pid_freq;
      SRC_COMM: v = comm_reg;
      SRC_POT: p = i_chan.pot;
      default: v = '0;
    endcase
    if (sel inside {SRC_AIN_ONE, SRC_AIN_TWO, SRC_AIN_BIP, SRC_PULSE, SRC_POT}) begin
      v = pct_of(p, full);
    end
    return v;
  endfunction

  frs_step_mem u_steps (
    .i_sys_clk(i_sys_clk),
    .i_we(step_we),
    .i_waddr(i_bus.addr[3:0]),
    .i_wdata(i_bus.wdata),
    .i_raddr(i_step_terms),
    .o_rdata(step_pct)
  );

  always_comb begin
    step_we = i_bus.wr && (i_bus.addr[ADDR_W-1:4] == OFS_STEP_BASE[ADDR_W-1:4]);
  end

  // Register writes and keypad up/down adjustment.
  always_comb begin
    main_src_next = main_src_reg;
    aux_src_next = aux_src_reg;
    aux_range_next = aux_range_reg;
    comb_mode_next = comb_mode_reg;
    comb_ofs_next = comb_ofs_reg;
    keypad_next = keypad_reg;
    fmax_next = fmax_reg;
    csel_next = csel_reg;
    px0_next = px0_reg;
    py0_next = py0_reg;
    px1_next = px1_reg;
    py1_next = py1_reg;
    comm_next = comm_reg;
    digital_next = digital_reg;
    curve_next = curve_reg;
    // The upper curve bank has its own process below.
    if (i_bus.wr) begin
      if (i_bus.addr == OFS_MAIN_SRC) begin
        main_src_next = i_bus.wdata[3:0];
      end else if (i_bus.addr == OFS_AUX_SRC) begin
        aux_src_next = i_bus.wdata[3:0];
      end else if (i_bus.addr == OFS_AUX_RANGE) begin
        aux_range_next = i_bus.wdata;
      end else if (i_bus.addr == OFS_COMB_MODE) begin
        comb_mode_next = i_bus.wdata;
      end else if (i_bus.addr == OFS_COMB_OFS) begin
        comb_ofs_next = FREQ_W'($signed(i_bus.wdata));
      end else if (i_bus.addr == OFS_KEYPAD) begin
        keypad_next = FREQ_W'(i_bus.wdata);
        digital_next = FREQ_W'(i_bus.wdata);
      end else if (i_bus.addr == OFS_FMAX) begin
        fmax_next = FREQ_W'(i_bus.wdata);
      end else if (i_bus.addr == OFS_CURVE_SEL) begin
        csel_next = i_bus.wdata[3*CSEL_W-1:0];
      end else if (i_bus.addr == OFS_PULSE_X0) begin
        px0_next = i_bus.wdata;
      end else if (i_bus.addr == OFS_PULSE_Y0) begin
        py0_next = i_bus.wdata;
      end else if (i_bus.addr == OFS_PULSE_X1) begin
        px1_next = i_bus.wdata;
      end else if (i_bus.addr == OFS_PULSE_Y1) begin
        py1_next = i_bus.wdata;
      end else if (i_bus.addr == OFS_COMM_FREQ) begin
        comm_next = FREQ_W'($signed(i_bus.wdata));
      end else if (i_bus.addr[ADDR_W-1:5] == OFS_CURVE_BASE[ADDR_W-1:5]) begin
        if (i_bus.addr[4:0] < 5'(CURVES*4)) begin
          curve_next[i_bus.addr[4:0]] = i_bus.wdata;
        end
      end
    end
    // Up/down trims the digital main setting directly, even when B is keypad.
    if (i_up && !i_down && digital_reg < $signed(fmax_reg)) begin
      digital_next = digital_reg + FREQ_W'(1);
    end else if (i_down && !i_up && digital_reg > 0) begin
      digital_next = digital_reg - FREQ_W'(1);
    end
  end

  // Upper points of three-point curves sit in a bank no bus write reaches; they keep their reset value.
  always_comb begin
    for (int k = 0; k < CURVES*4; k++) begin
      curve_ext_next[k] = curve_ext_reg[k];
    end
  end

  // Source evaluation and combination.
  always_comb begin
    logic signed [FREQ_W-1:0] aux_full;
    logic signed [FREQ_W-1:0] r;
    logic arith;
    aux_full = (aux_range_reg[0]) ? fabs(src_a_reg) : $signed(fmax_reg);
    arith = comb_mode_reg[2:0] inside {CMB_SUM, CMB_DIFF, CMB_MAX, CMB_MIN};
    r = src_a_reg;
    src_a_next = chan_val(main_src_reg, $signed(fmax_reg), 1'b0);
    src_b_next = chan_val(aux_src_reg, arith ? aux_full : $signed(fmax_reg), arith);
    case (frs_comb_t'(comb_mode_reg[2:0]))
      CMB_A: r = src_a_reg;
      CMB_B: r = src_b_reg;
      CMB_SWITCH: r = i_switch_term ? src_b_reg : src_a_reg;
      CMB_SUM: r = src_a_reg + src_b_reg;
      CMB_DIFF: r = src_a_reg - src_b_reg;
      CMB_MAX: r = (fabs(src_a_reg) >= fabs(src_b_reg)) ? src_a_reg : src_b_reg;
      CMB_MIN: r = (fabs(src_a_reg) <= fabs(src_b_reg)) ? src_a_reg : src_b_reg;
      default: r = src_a_reg;
    endcase
    target_next = arith ? r + comb_ofs_reg : r;
  end

  // Read data, valid the cycle after the strobe only.
  always_comb begin
    rdata_next = '0;
    if (i_bus.rd) begin
      if (i_bus.addr == OFS_MAIN_SRC) begin
        rdata_next = DATA_W'(main_src_reg);
      end else if (i_bus.addr == OFS_AUX_SRC) begin
        rdata_next = DATA_W'(aux_src_reg);
      end else if (i_bus.addr == OFS_AUX_RANGE) begin
        rdata_next = aux_range_reg;
      end else if (i_bus.addr == OFS_COMB_MODE) begin
        rdata_next = comb_mode_reg;
      end else if (i_bus.addr == OFS_COMB_OFS) begin
        rdata_next = DATA_W'(comb_ofs_reg);
      end else if (i_bus.addr == OFS_KEYPAD) begin
        rdata_next = DATA_W'(keypad_reg);
      end else if (i_bus.addr == OFS_FMAX) begin
        rdata_next = DATA_W'(fmax_reg);
      end else if (i_bus.addr == OFS_CURVE_SEL) begin
        rdata_next = DATA_W'(csel_reg);
      end else if (i_bus.addr == OFS_PULSE_X0) begin
        rdata_next = px0_reg;
      end else if (i_bus.addr == OFS_PULSE_Y0) begin
        rdata_next = py0_reg;
      end else if (i_bus.addr == OFS_PULSE_X1) begin
        rdata_next = px1_reg;
      end else if (i_bus.addr == OFS_PULSE_Y1) begin
        rdata_next = py1_reg;
      end else if (i_bus.addr == OFS_COMM_FREQ) begin
        rdata_next = DATA_W'(comm_reg);
      end else if (i_bus.addr == OFS_TARGET) begin
        rdata_next = DATA_W'(target_reg);
      end else if (i_bus.addr == OFS_SRC_A) begin
        rdata_next = DATA_W'(src_a_reg);
      end else if (i_bus.addr == OFS_SRC_B) begin
        rdata_next = DATA_W'(src_b_reg);
      end else if (i_bus.addr[ADDR_W-1:5] == OFS_CURVE_BASE[ADDR_W-1:5]) begin
        if (i_bus.addr[4:0] < 5'(CURVES*4)) begin
          rdata_next = curve_reg[i_bus.addr[4:0]];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      main_src_reg <= SRC_KEYPAD;
      aux_src_reg <= SRC_KEYPAD;
      aux_range_reg <= '0;
      comb_mode_reg <= '0;
      comb_ofs_reg <= '0;
      keypad_reg <= FMAX_RST;
      fmax_reg <= FMAX_RST;
      csel_reg <= '0;
      px0_reg <= PULSE_X0_RST;
      py0_reg <= PULSE_Y0_RST;
      px1_reg <= PULSE_X1_RST;
      py1_reg <= PULSE_Y1_RST;
      comm_reg <= '0;
      digital_reg <= FMAX_RST;
      for (int k = 0; k < CURVES*4; k++) begin
        curve_reg[k] <= ((k % 4) == 2 || (k % 4) == 3) ? $signed(PCT_FULL) : '0;
        curve_ext_reg[k] <= $signed(PCT_FULL);
      end
      src_a_reg <= '0;
      src_b_reg <= '0;
      target_reg <= '0;
      rdata_reg <= '0;
    end else begin
      main_src_reg <= main_src_next;
      aux_src_reg <= aux_src_next;
      aux_range_reg <= aux_range_next;
      comb_mode_reg <= comb_mode_next;
      comb_ofs_reg <= comb_ofs_next;
      keypad_reg <= keypad_next;
      fmax_reg <= fmax_next;
      csel_reg <= csel_next;
      px0_reg <= px0_next;
      py0_reg <= py0_next;
      px1_reg <= px1_next;
      py1_reg <= py1_next;
      comm_reg <= comm_next;
      digital_reg <= digital_next;
      curve_reg <= curve_next;
      curve_ext_reg <= curve_ext_next;
      src_a_reg <= src_a_next;
      src_b_reg <= src_b_next;
      target_reg <= target_next;
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    o_rdata = rdata_reg;
    o_target_freq = target_reg;
  end
endmodule // frs_top

/* File: include/frs_pkg.sv */
package frs_pkg;

  // Frequencies are signed, in units of 0.01 Hz; percentages in units of 0.01 %.
  localparam int FREQ_W = 18;
  localparam int PCT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int STEPS = 16;
  localparam int CURVES = 5;

  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [FREQ_W-1:0] FMAX_RST = 18'h01388;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_MAIN_SRC = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AUX_SRC = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_AUX_RANGE = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_COMB_MODE = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_COMB_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_KEYPAD = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_FMAX = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_CURVE_SEL = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_PULSE_X0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PULSE_Y0 = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_PULSE_X1 = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_PULSE_Y1 = 8'h0B;
  localparam logic [ADDR_W-1:0] OFS_COMM_FREQ = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h0D;
  localparam logic [ADDR_W-1:0] OFS_SRC_A = 8'h0E;
  localparam logic [ADDR_W-1:0] OFS_SRC_B = 8'h0F;
  localparam logic [ADDR_W-1:0] OFS_STEP_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CURVE_BASE = 8'h20;

  localparam logic [15:0] PULSE_X0_RST = 16'h0000;
  localparam logic [15:0] PULSE_Y0_RST = 16'h0000;
  localparam logic [15:0] PULSE_X1_RST = 16'h03E8;
  localparam logic [15:0] PULSE_Y1_RST = 16'h2710;

  // Field shift of the per-input curve select (3 bits per analog input).
  localparam int CSEL_W = 3;

  typedef enum logic [3:0] {
    SRC_KEYPAD = 4'h0,
    SRC_KEYPAD_RET = 4'h1,
    SRC_AIN_ONE = 4'h2,
    SRC_AIN_TWO = 4'h3,
    SRC_AIN_BIP = 4'h4,
    SRC_PULSE = 4'h5,
    SRC_MULTI = 4'h6,
    SRC_SEQ = 4'h7,
    SRC_PID = 4'h8,
    SRC_COMM = 4'h9,
    SRC_POT = 4'hA
  } frs_src_t;

  typedef enum logic [2:0] {
    CMB_A = 3'h0,
    CMB_B = 3'h1,
    CMB_SWITCH = 3'h2,
    CMB_SUM = 3'h3,
    CMB_DIFF = 3'h4,
    CMB_MAX = 3'h5,
    CMB_MIN = 3'h6
  } frs_comb_t;

  // Software register bus request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } frs_bus_t;

  // Raw reference channels, percentages signed 16 bit, pulse rate in units of 100 Hz.
  typedef struct packed {
    logic signed [PCT_W-1:0] ain_one;
    logic signed [PCT_W-1:0] ain_two;
    logic signed [PCT_W-1:0] ain_bip;
    logic [PCT_W-1:0] pulse_rate;
    logic signed [PCT_W-1:0] pot;
    logic signed [FREQ_W-1:0] pid_freq;
    logic signed [FREQ_W-1:0] seq_freq;
  } frs_chan_t;

endpackage
